// File: design/sdm_driver.sv
// step/direction command input logic of the integrated motor driver
`timescale 1ns/1ps
// Functional notes
// - each rising step pulse edge moves one microstep while the driver is on; falling edges do nothing
// - resolution low gives 1/8 step (1600/rev), high gives 1/256 (51200/rev)
// - direction low turns clockwise, high turns counter-clockwise
// - enable low switches winding current off, high switches it on
// - resolution is taken only while enable is low
// - boost high raises current above nominal, low keeps nominal
// - at standstill current drops to two thirds of nominal
// - over-temperature or supply fault switches driver off and latches
// - after a fault only a rising enable edge with fault cleared restarts
module sdm_driver
  import sdm_pkg::*;
#(
  parameter int unsigned STANDSTILL_CYCLES = STANDSTILL_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // controller inputs
  input wire logic pulse_in,
  input wire logic dir_in,
  input wire logic res_sel_in,
  input wire logic enable_in,
  input wire logic boost_in,
  // protection sensors
  input wire logic over_temp_in,
  input wire logic supply_fault_in,
  // driver outputs
  output logic [CUR_W-1:0] cur_ref_r,
  output logic [POS_W-1:0] rotor_pos,
  output logic fine_res_r,
  output logic driver_on_r,
  output logic standstill_r,
  output logic fault_r
);
  localparam int unsigned IDLE_W = $clog2(STANDSTILL_CYCLES + 1);

  if (STANDSTILL_CYCLES < 1) begin : g_chk
    $error("standstill time must be at least one cycle");
  end

  sdm_state_t state_r;
  sdm_state_t state_nxt;
  logic pulse_prev_r;
  logic enable_prev_r;
  logic [IDLE_W-1:0] idle_r;
  logic [CUR_W-1:0] cur_nxt;
  logic fault_cond;
  logic enable_rise;
  logic drive_active;
  logic step_evt;
  logic idle_done;

  sdm_step_if stp ();

  // input edge history
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_prev_r <= 1'b0;
      enable_prev_r <= 1'b0;
    end else begin
      pulse_prev_r <= pulse_in;
      enable_prev_r <= enable_in;
    end
  end

  assign fault_cond = over_temp_in | supply_fault_in;
  assign enable_rise = enable_in & ~enable_prev_r;
  assign drive_active = (state_r == SDM_RUN) || (state_r == SDM_HOLD);
  // rising edge only, and only while driving
  assign step_evt = pulse_in & ~pulse_prev_r & drive_active;
  assign idle_done = (idle_r == IDLE_W'(STANDSTILL_CYCLES - 1));

  // resolution latch
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fine_res_r <= 1'b0;
    end else if (!enable_in) begin
      fine_res_r <= res_sel_in;
    end
  end

  // step events to the position counter
  assign stp.step = step_evt;
  assign stp.ccw = dir_in;
  assign stp.fine = fine_res_r;
  assign rotor_pos = stp.pos;

  sdm_position u_sdm_position (
    .mclk(mclk),
    .arst_n(arst_n),
    .stp(stp)
  );

  // standstill timer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      idle_r <= '0;
    end else if (step_evt || state_r != SDM_RUN) begin
      idle_r <= '0;
    end else if (!idle_done) begin
      idle_r <= idle_r + IDLE_W'(1);
    end
  end

  // driver state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SDM_OFF: begin
        if (enable_in) begin
          state_nxt = SDM_RUN;
        end
      end
      SDM_RUN: begin
        if (!enable_in) begin
          state_nxt = SDM_OFF;
        end else if (idle_done && !step_evt) begin
          state_nxt = SDM_HOLD;
        end
      end
      SDM_HOLD: begin
        if (!enable_in) begin
          state_nxt = SDM_OFF;
        end else if (step_evt) begin
          state_nxt = SDM_RUN;
        end
      end
      SDM_FAULT: begin
        if (enable_rise && !fault_cond) begin
          state_nxt = SDM_RUN;
        end
      end
      default: begin
        state_nxt = SDM_OFF;
      end
    endcase
    if (fault_cond) begin
      state_nxt = SDM_FAULT;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= SDM_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // current reference
  always_comb begin
    case (state_nxt)
      SDM_RUN: cur_nxt = boost_in ? CUR_BOOST : CUR_NOMINAL;
      SDM_HOLD: cur_nxt = CUR_REDUCED;
      default: cur_nxt = CUR_OFF;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cur_ref_r <= CUR_OFF;
      driver_on_r <= 1'b0;
      standstill_r <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      cur_ref_r <= cur_nxt;
      driver_on_r <= (state_nxt == SDM_RUN) || (state_nxt == SDM_HOLD);
      standstill_r <= (state_nxt == SDM_HOLD);
      fault_r <= (state_nxt == SDM_FAULT);
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_step_moves_rotor: assert property (
    step_evt |=> rotor_pos != $past(rotor_pos))
    else $error("step edge did not move rotor");

  a_no_edge_still: assert property (
    !step_evt |=> $stable(rotor_pos))
    else $error("rotor moved without rising step edge");

  a_fine_cw_step: assert property (
    step_evt && fine_res_r && !dir_in && rotor_pos < USTEP_PER_REV - INC_FINE
    |=> rotor_pos == $past(rotor_pos) + INC_FINE)
    else $error("fine step size wrong");

  a_coarse_cw_step: assert property (
    step_evt && !fine_res_r && !dir_in && rotor_pos < USTEP_PER_REV - INC_COARSE
    |=> rotor_pos == $past(rotor_pos) + INC_COARSE)
    else $error("coarse step size wrong");

  a_ccw_step_back: assert property (
    step_evt && !fine_res_r && dir_in && rotor_pos >= INC_COARSE
    |=> rotor_pos == $past(rotor_pos) - INC_COARSE)
    else $error("counter-clockwise step wrong");

  a_disable_cuts_current: assert property (
    !enable_in |=> cur_ref_r == CUR_OFF && !driver_on_r)
    else $error("current not off with enable low");

  a_res_frozen_enabled: assert property (
    enable_in |=> $stable(fine_res_r))
    else $error("resolution changed while enabled");

  a_boost_level: assert property (
    state_r == SDM_RUN |-> cur_ref_r == ($past(boost_in) ? CUR_BOOST : CUR_NOMINAL))
    else $error("run current does not follow boost");

  a_standstill_reduce: assert property (
    state_r == SDM_HOLD |-> cur_ref_r == CUR_REDUCED && standstill_r)
    else $error("standstill current not reduced");

  a_fault_cutoff: assert property (
    fault_cond |=> state_r == SDM_FAULT && cur_ref_r == CUR_OFF && fault_r)
    else $error("fault did not cut driver off");

  a_fault_latched: assert property (
    state_r == SDM_FAULT && !(enable_rise && !fault_cond) |=> state_r == SDM_FAULT)
    else $error("fault released without enable edge");

  a_fault_restart: assert property (
    state_r == SDM_FAULT && enable_rise && !fault_cond |=> state_r == SDM_RUN && driver_on_r)
    else $error("enable edge did not restart driver");

  a_drop_idle_pulses: assert property (
    !drive_active |=> $stable(rotor_pos))
    else $error("pulse accepted while inactive");
endmodule : sdm_driver

// File: inc/sdm_pkg.sv
// constants and types for the step/direction motor input logic
package sdm_pkg;
  // clock
  localparam int unsigned CLK_HZ = 10_000_000;
  // standstill detection time before current reduction
  localparam int unsigned STANDSTILL_MS = 50;
  localparam int unsigned STANDSTILL_CYC = STANDSTILL_MS * (CLK_HZ / 1000);
  // highest step rate the controller may use
  localparam int unsigned MAX_STEP_HZ = 200_000;
  localparam int unsigned MIN_STEP_CYC = CLK_HZ / MAX_STEP_HZ;
  // position counting
  localparam int unsigned POS_W = 16;
  localparam logic [15:0] USTEP_PER_REV = 16'hC800;
  localparam logic [15:0] INC_FINE = 16'h0001;
  localparam logic [15:0] INC_COARSE = 16'h0020;
  localparam logic [15:0] POS_RST = 16'h0000;
  // winding current reference, reduced is exactly 2/3 of nominal
  localparam int unsigned CUR_W = 8;
  localparam logic [7:0] CUR_OFF = 8'h00;
  localparam logic [7:0] CUR_NOMINAL = 8'hC0;
  localparam logic [7:0] CUR_REDUCED = 8'h80;
  localparam logic [7:0] CUR_BOOST = 8'hFF;
  // driver states, gray along off -> run -> hold, fault beside
  typedef enum logic [1:0] {
    SDM_OFF = 2'b00,
    SDM_RUN = 2'b01,
    SDM_HOLD = 2'b11,
    SDM_FAULT = 2'b10
  } sdm_state_t;
endpackage : sdm_pkg

// File: inc/sdm_step_if.sv
// step event carrier between control and position counter
`timescale 1ns/1ps
interface sdm_step_if;
  import sdm_pkg::*;
  logic step;
  logic ccw;
  logic fine;
  logic [POS_W-1:0] pos;
  modport ctrl (output step, output ccw, output fine, input pos);
  modport cnt (input step, input ccw, input fine, output pos);
endinterface : sdm_step_if

// File: design/sdm_position.sv
// microstep position counter, one revolution wide
`timescale 1ns/1ps
module sdm_position
  import sdm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // step events
  sdm_step_if.cnt stp
);
  logic [POS_W-1:0] pos_r;
  logic [POS_W-1:0] pos_nxt;
  logic [POS_W-1:0] inc;

  assign stp.pos = pos_r;

  always_comb begin
    inc = stp.fine ? INC_FINE : INC_COARSE;
    pos_nxt = pos_r;
    if (stp.step) begin
      if (stp.ccw) begin
        if (pos_r < inc) begin
          pos_nxt = pos_r + USTEP_PER_REV - inc;
        end else begin
          pos_nxt = pos_r - inc;
        end
      end else begin
        if (pos_r >= USTEP_PER_REV - inc) begin
          pos_nxt = pos_r + inc - USTEP_PER_REV;
        end else begin
          pos_nxt = pos_r + inc;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pos_r <= POS_RST;
    end else begin
      pos_r <= pos_nxt;
    end
  end
endmodule : sdm_position

// File: verification/sdm_ctrl_model.sv
// controller model driving step pulse and direction
`timescale 1ns/1ps
module sdm_ctrl_model (
  // clock
  input wire logic mclk,
  // controller pins
  output logic pulse_in,
  output logic dir_in
);
  initial begin
    pulse_in = 1'b0;
    dir_in = 1'b0;
  end
  // direction settles a cycle ahead, then the pulse rises
  task automatic rise(input logic d);
    @(negedge mclk) dir_in = d;
    @(negedge mclk) pulse_in = 1'b1;
  endtask : rise
  // 25 cycles high and 25 low, plus the two cycles of rise, keep the rate below 200 kHz
  task automatic fall();
    repeat (25) @(negedge mclk);
    pulse_in = 1'b0;
    repeat (25) @(negedge mclk);
  endtask : fall
  task automatic steps(input int n, input logic d);
    repeat (n) begin
      rise(d);
      fall();
    end
  endtask : steps
endmodule : sdm_ctrl_model

// File: verification/sdm_driver_tb.sv
// self-checking bench for the step/direction driver
`timescale 1ns/1ps
module sdm_driver_tb;
  import sdm_pkg::*;
  localparam int unsigned SS = 8;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic pulse_in, dir_in;
  logic res_sel_in = 1'b0, enable_in = 1'b0, boost_in = 1'b0;
  logic over_temp_in = 1'b0, supply_fault_in = 1'b0;
  logic [CUR_W-1:0] cur_ref_r;
  logic [POS_W-1:0] rotor_pos;
  logic fine_res_r, driver_on_r, standstill_r, fault_r;
  int n_fail = 0, tests_run = 0, cyc = 0;

  always #50 mclk = ~mclk;

  sdm_driver #(.STANDSTILL_CYCLES(SS)) u_sdm_driver (
    .mclk, .arst_n, .pulse_in, .dir_in, .res_sel_in, .enable_in, .boost_in,
    .over_temp_in, .supply_fault_in, .cur_ref_r, .rotor_pos, .fine_res_r,
    .driver_on_r, .standstill_r, .fault_r
  );
  sdm_ctrl_model u_sdm_ctrl_model (.mclk, .pulse_in, .dir_in);

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end

  task automatic t_enable();
    @(negedge mclk) enable_in = 1'b1;
    @(negedge mclk) chk(16'(cur_ref_r), 16'(CUR_NOMINAL));
    chk(16'(driver_on_r), 16'h0001);
    boost_in = 1'b1;
    @(negedge mclk) chk(16'(cur_ref_r), 16'(CUR_BOOST));
    boost_in = 1'b0;
  endtask : t_enable

  task automatic t_steps();
    u_sdm_ctrl_model.steps(3, 1'b0);
    chk(rotor_pos, INC_COARSE * 16'h0003);
    u_sdm_ctrl_model.steps(4, 1'b1);
    chk(rotor_pos, USTEP_PER_REV - INC_COARSE);
    res_sel_in = 1'b1;
    repeat (2) @(negedge mclk);
    chk(16'(fine_res_r), 16'h0000);
    enable_in = 1'b0;
    repeat (2) @(negedge mclk);
    chk(16'(fine_res_r), 16'h0001);
    chk(16'(cur_ref_r), 16'(CUR_OFF));
    u_sdm_ctrl_model.steps(2, 1'b0);
    chk(rotor_pos, USTEP_PER_REV - INC_COARSE);
    enable_in = 1'b1;
    u_sdm_ctrl_model.steps(1, 1'b1);
    chk(rotor_pos, USTEP_PER_REV - INC_COARSE - INC_FINE);
  endtask : t_steps

  task automatic t_standstill();
    boost_in = 1'b1;
    repeat (SS + 4) @(negedge mclk);
    chk(16'(standstill_r), 16'h0001);
    chk(16'(cur_ref_r), 16'(CUR_REDUCED));
    u_sdm_ctrl_model.rise(1'b0);
    repeat (2) @(negedge mclk);
    chk(16'(cur_ref_r), 16'(CUR_BOOST));
    u_sdm_ctrl_model.fall();
    boost_in = 1'b0;
  endtask : t_standstill

  task automatic t_fault(input int k);
    logic [15:0] p;
    p = rotor_pos;
    over_temp_in = (k == 0);
    supply_fault_in = (k == 1);
    repeat (2) @(negedge mclk);
    chk(16'(fault_r), 16'h0001);
    chk(16'(cur_ref_r), 16'(CUR_OFF));
    over_temp_in = 1'b0;
    supply_fault_in = 1'b0;
    u_sdm_ctrl_model.steps(1, 1'b0);
    chk(16'(driver_on_r), 16'h0000);
    chk(rotor_pos, p);
    enable_in = 1'b0;
    @(negedge mclk) enable_in = 1'b1;
    repeat (2) @(negedge mclk);
    chk(16'(driver_on_r), 16'h0001);
  endtask : t_fault

  initial begin
    repeat (8) @(negedge mclk);
    arst_n = 1'b1;
    t_enable();
    t_steps();
    t_standstill();
    t_fault(0);
    t_fault(1);
    results();
  end
endmodule : sdm_driver_tb
